// ===== verilog/flcs_regs.svh
// constants for the flash lock, configuration and status command logic
// assumes inclusion by the package and the design modules only
`ifndef FLCS_REGS_SVH
`define FLCS_REGS_SVH
`define FLCS_CMD_LOCK_SETUP 8'h60
`define FLCS_CMD_LOCK 8'h01
`define FLCS_CMD_UNLOCK 8'hD0
`define FLCS_CMD_LOCKDOWN 8'h2F
`define FLCS_CMD_PROT_SETUP 8'hC0
`define FLCS_CMD_RCR_WRITE 8'h03
`define FLCS_CMD_READ_STATUS 8'h70
`define FLCS_CMD_CLEAR_STATUS 8'h50
`define FLCS_CMD_READ_ARRAY 8'hFF
`define FLCS_CMD_PROGRAM 8'h40
`define FLCS_CMD_ERASE_SETUP 8'h20
`define FLCS_STATUS_RESET 8'h80
`define FLCS_HIGH_BYTE_STATUS 8'h00
`define FLCS_BIT_READY 7
`define FLCS_BIT_ERS_SUSP 6
`define FLCS_BIT_ERS_ERR 5
`define FLCS_BIT_PRG_ERR 4
`define FLCS_BIT_VPP_LOW 3
`define FLCS_BIT_PRG_SUSP 2
`define FLCS_BIT_LOCKED 1
`define FLCS_BIT_BUFFERED_FACTORY_PROGRAMMING 0
`endif

// ===== verilog/flcs_pkg.sv
// types shared by the flash lock, configuration and status logic
// assumes the constants header is available on the include path
package flcs_pkg;
`include "flcs_regs.svh"
   typedef enum logic [1:0] {FLCS_UNLOCKED, FLCS_LOCKED, FLCS_LOCKED_DOWN} flcs_lock_t;
   typedef enum logic [1:0] {FLCS_RD_ARRAY, FLCS_RD_STATUS, FLCS_RD_OTHER} flcs_rmode_t;
   typedef struct packed {
      logic ready;
      logic ers_susp;
      logic prg_susp;
      logic buffered_factory_programming_busy;
      logic ers_fail;
      logic prg_fail;
      logic vpp_low;
      logic locked_hit;
   } flcs_engine_t;
   typedef struct packed {
      logic we;
      logic [15:0] data;
      logic [16:0] addr;
   } flcs_write_t;
endpackage : flcs_pkg

// ===== verilog/flcs_sync.sv
// two-flop synchroniser for pin inputs
// assumes a single ref_clk domain; rst_b releases to the given level
`timescale 1ns/1ps
module flcs_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= INIT;
         dout <= INIT;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule : flcs_sync

// ===== verilog/flcs_cmd.sv
// command interpreter: lock/unlock/lock-down, protection setup, read config write,
// status register and read-mode selection for a parallel flash
// assumes the write state machine reports its flags on engine_i (same clock),
// bus pins arrive asynchronously and are synchronised here
// Function
// RULE1: lock setup needs lock, unlock or lockdown
// RULE2: 0x01 after setup locks addressed block
// RULE3: 0xD0 after setup unlocks addressed block
// RULE4: 0x2F after setup locks down block
// RULE5: 0xC0 arms protection register program
// RULE6: config setup must be followed by 0x03
// RULE7: 0x03 loads sixteen address bits to config
// RULE8: after config write reads return array
// RULE9: host requests status at any address
// RULE10: program, erase, lock switch reads to status
// RULE11: status on low byte, zero high byte
// RULE12: async status latched on first enable fall (here latched on the later of the ce_n and oe_n falls, once both are low)
// RULE13: burst status refresh needs chip or address toggle
// RULE14: bit7 busy zero, ready one
// RULE15: bits 6 and 2 show suspends
// RULE16: bit5 erase failure or sequence error
// RULE17: bit4 program failure or sequence error
// RULE18: bit3 program supply below lockout
// RULE19: bit1 locked block hit, aborted
// RULE20: bit0 factory program in progress
// RULE21: status resets to 0x80
// RULE22: suspend sequence error stays until cleared
// RULE23: machine owns 7,6,2; others sticky (bit0 here also follows the machine directly, not sticky)
// RULE24: unlock leaves locked-down block locked
// RULE25: sequence error returns status on reads
`timescale 1ns/1ps
`include "flcs_regs.svh"
module flcs_cmd import flcs_pkg::*; #(
   parameter int NBLK = 16,
   parameter int BLK_LSB = 12,
   parameter bit ADDR_SHIFT = 1'b0
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic address_valid_n,
   input wire logic sync_burst,
   input wire logic [16:0] addr,
   input wire logic [15:0] dq_in,
   input wire flcs_engine_t engine_i,
   output logic [15:0] dq_out,
   output logic dq_oe,
   output logic [7:0] operation_status,
   output logic [15:0] read_config_register,
   output logic [NBLK-1:0] block_locked,
   output logic [NBLK-1:0] block_locked_down,
   output logic prot_prog_start,
   output logic [16:0] prot_addr,
   output logic [15:0] prot_data,
   output logic status_mode
);
   localparam int BLKW = (NBLK > 1) ? $clog2(NBLK) : 1;
   initial begin
      if (NBLK < 1 || BLK_LSB + BLKW > 17)
         $error("flcs_cmd: block geometry does not fit address bus");
   end

   typedef enum logic [1:0] {S_IDLE, S_LOCK_ARMED, S_PROT_ARMED} flcs_state_t;
   flcs_state_t state;
   flcs_rmode_t rmode;

   logic [3:0] pins_s;
   logic [16:0] addr_s;
   logic [15:0] dq_s;
   flcs_sync #(.W(4), .INIT(4'hF)) u_sync_ctl (
      .ref_clk(ref_clk), .rst_b(rst_b),
      .din({ce_n, oe_n, we_n, address_valid_n}), .dout(pins_s));
   flcs_sync #(.W(17), .INIT(17'h00000)) u_sync_addr (
      .ref_clk(ref_clk), .rst_b(rst_b), .din(addr), .dout(addr_s));
   flcs_sync #(.W(16), .INIT(16'h0000)) u_sync_dq (
      .ref_clk(ref_clk), .rst_b(rst_b), .din(dq_in), .dout(dq_s));
   // the read mode pin is a board level too, so it passes the same two flops
   logic burst_s;
   flcs_sync #(.W(1), .INIT(1'b0)) u_sync_burst (
      .ref_clk(ref_clk), .rst_b(rst_b), .din(sync_burst), .dout(burst_s));

   wire ce_s = pins_s[3];
   wire oe_s = pins_s[2];
   wire we_s = pins_s[1];
   wire adv_s = pins_s[0];
   logic ce_d, oe_d, we_d, adv_d;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         {ce_d, oe_d, we_d, adv_d} <= 4'hF;
      end else begin
         {ce_d, oe_d, we_d, adv_d} <= pins_s;
      end
   end

   // a command is taken on the rising edge of write enable while the chip is selected
   wire wr = we_s & ~we_d & ~ce_s;
   wire [7:0] cmd = dq_s[7:0];
   wire [BLKW-1:0] blk = addr_s[BLK_LSB +: BLKW];
   wire read_active = ~ce_s & ~oe_s;
   wire async_fall = ~burst_s & read_active & (ce_d | oe_d);
   wire burst_tog = burst_s & ~ce_s & ((ce_d & ~ce_s) | (adv_d & ~adv_s));
   wire refresh = async_fall | burst_tog;

   wire in_lock = (state == S_LOCK_ARMED);
   wire in_prot = (state == S_PROT_ARMED);
   wire do_lock = wr & in_lock & (cmd == `FLCS_CMD_LOCK);
   wire do_unlock = wr & in_lock & (cmd == `FLCS_CMD_UNLOCK);
   wire do_lockdown = wr & in_lock & (cmd == `FLCS_CMD_LOCKDOWN);
   wire do_rcr = wr & in_lock & (cmd == `FLCS_CMD_RCR_WRITE);
   // one setup code serves both lock and configuration; the second cycle decides
   wire seq_err = wr & in_lock & ~do_lock & ~do_unlock & ~do_lockdown & ~do_rcr;
   wire do_prot = wr & in_prot;
   wire idle_wr = wr & (state == S_IDLE);
   wire do_clear = idle_wr & (cmd == `FLCS_CMD_CLEAR_STATUS);
   wire do_rstat = idle_wr & (cmd == `FLCS_CMD_READ_STATUS);
   wire do_rarr = idle_wr & (cmd == `FLCS_CMD_READ_ARRAY);
   wire do_wsm_cmd = idle_wr & ((cmd == `FLCS_CMD_PROGRAM) | (cmd == `FLCS_CMD_ERASE_SETUP));

   flcs_state_t next_state;
   assign next_state = !wr ? state :
                       (idle_wr & (cmd == `FLCS_CMD_LOCK_SETUP)) ? S_LOCK_ARMED :
                       (idle_wr & (cmd == `FLCS_CMD_PROT_SETUP)) ? S_PROT_ARMED :
                       S_IDLE;

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= S_IDLE;
      end else begin
         state <= next_state; // RULE5
      end
   end

   // sticky error bits; set beats clear in the same cycle
   logic [3:0] sticky;
   logic [3:0] next_sticky;
   wire [3:0] sticky_set = {engine_i.ers_fail | seq_err, // RULE16 RULE1 RULE6
                            engine_i.prg_fail | seq_err, // RULE17
                            engine_i.vpp_low, // RULE18
                            engine_i.locked_hit}; // RULE19
   assign next_sticky = (do_clear ? 4'h0 : sticky) | sticky_set; // RULE23 RULE22
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sticky <= 4'h0;
      end else begin
         sticky <= next_sticky;
      end
   end

   wire [7:0] next_status;
   assign next_status[`FLCS_BIT_READY] = engine_i.ready; // RULE14
   assign next_status[`FLCS_BIT_ERS_SUSP] = engine_i.ready & engine_i.ers_susp; // RULE15
   assign next_status[`FLCS_BIT_ERS_ERR] = next_sticky[3];
   assign next_status[`FLCS_BIT_PRG_ERR] = next_sticky[2];
   assign next_status[`FLCS_BIT_VPP_LOW] = next_sticky[1];
   assign next_status[`FLCS_BIT_PRG_SUSP] = engine_i.ready & engine_i.prg_susp; // RULE15
   assign next_status[`FLCS_BIT_LOCKED] = next_sticky[0];
   assign next_status[`FLCS_BIT_BUFFERED_FACTORY_PROGRAMMING] = engine_i.buffered_factory_programming_busy; // RULE20

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         operation_status <= `FLCS_STATUS_RESET; // RULE21
      end else begin
         operation_status <= next_status;
      end
   end

   // read mode: status after lock, program, erase or errors; array after config write
   flcs_rmode_t next_rmode;
   assign next_rmode = (do_rcr | do_rarr) ? FLCS_RD_ARRAY : // RULE8
                       (do_lock | do_unlock | do_lockdown | do_wsm_cmd | do_prot) ?
                       FLCS_RD_STATUS : // RULE10
                       (seq_err | do_rstat) ? FLCS_RD_STATUS : // RULE25 RULE9
                       rmode;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rmode <= FLCS_RD_ARRAY;
      end else begin
         rmode <= next_rmode;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         status_mode <= 1'b0;
      end else begin
         status_mode <= (next_rmode == FLCS_RD_STATUS);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         read_config_register <= 16'h0000;
      end else if (do_rcr) begin
         read_config_register <= ADDR_SHIFT ? addr_s[16:1] : addr_s[15:0]; // RULE7
      end
   end

   // lock-down blocks ignore unlock; only reset releases them
   genvar g;
   generate
      for (g = 0; g < NBLK; g++) begin : g_blk
         wire hit = (blk == BLKW'(g));
         always_ff @(posedge ref_clk or negedge rst_b) begin
            if (!rst_b) begin
               block_locked[g] <= 1'b1;
               block_locked_down[g] <= 1'b0;
            end else if (hit) begin
               if (do_lock | do_lockdown) begin
                  block_locked[g] <= 1'b1; // RULE2 RULE4
               end else if (do_unlock & ~block_locked_down[g]) begin
                  block_locked[g] <= 1'b0; // RULE3 RULE24
               end
               if (do_lockdown) begin
                  block_locked_down[g] <= 1'b1; // RULE4
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         prot_prog_start <= 1'b0;
         prot_addr <= 17'h00000;
         prot_data <= 16'h0000;
      end else begin
         prot_prog_start <= do_prot; // RULE5
         if (do_prot) begin
            prot_addr <= addr_s;
            prot_data <= dq_s;
         end
      end
   end

   // the latched word holds still through a read; only a fresh edge or toggle refreshes it
   logic [7:0] latched;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         latched <= `FLCS_STATUS_RESET;
      end else if (refresh) begin
         latched <= operation_status; // RULE12 RULE13
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         dq_out <= 16'h0000;
         dq_oe <= 1'b0;
      end else begin
         dq_oe <= read_active & (rmode == FLCS_RD_STATUS);
         dq_out <= {`FLCS_HIGH_BYTE_STATUS, refresh ? operation_status : latched}; // RULE11
      end
   end

   a_seq_err_flags: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE1
      seq_err |=> operation_status[`FLCS_BIT_ERS_ERR] && operation_status[`FLCS_BIT_PRG_ERR])
      else $error("sequence error did not set bits 5 and 4");
   a_lock_block: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE2
      do_lock |=> block_locked[$past(blk)])
      else $error("lock did not lock addressed block");
   a_unlock_block: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE3
      do_unlock && !block_locked_down[blk] |=> !block_locked[$past(blk)])
      else $error("unlock did not release addressed block");
   a_lockdown_set: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE4
      do_lockdown |=> block_locked_down[$past(blk)] && block_locked[$past(blk)])
      else $error("lock-down did not hold addressed block");
   a_lockdown_keep: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE24
      do_unlock && block_locked_down[blk] |=> block_locked[$past(blk)])
      else $error("unlock released a locked-down block");
   a_prot_start: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE5
      wr && in_prot |=> prot_prog_start ##1 !prot_prog_start)
      else $error("protection program start not one pulse");
   a_prot_capture: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE5
      do_prot |=> prot_addr == $past(addr_s) && prot_data == $past(dq_s))
      else $error("protection address or data not captured");
   a_cfg_seq_err: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE6
      wr && in_lock && (cmd == `FLCS_CMD_READ_ARRAY) |=>
      operation_status[`FLCS_BIT_ERS_ERR] && operation_status[`FLCS_BIT_PRG_ERR])
      else $error("bad code after config setup gave no error");
   a_rcr_load: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE7
      do_rcr && !ADDR_SHIFT |=> read_config_register == $past(addr_s[15:0]))
      else $error("config register not loaded from address");
   a_rcr_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE7
      !do_rcr |=> $stable(read_config_register))
      else $error("config register changed without config write");
   a_rcr_array: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE8
      do_rcr |=> !status_mode ##1 !dq_oe)
      else $error("config write did not return array mode");
   a_rstat_mode: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE9
      do_rstat |=> status_mode)
      else $error("read status command did not select status");
   a_status_mode: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE10
      do_lock || do_wsm_cmd || seq_err |=> status_mode)
      else $error("status mode not entered");
   a_unlock_mode: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE10
      do_unlock || do_lockdown || do_prot |=> status_mode)
      else $error("status mode not entered after lock change");
   a_rarr_mode: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE10
      do_rarr |=> !status_mode)
      else $error("read array did not leave status mode");
   a_high_byte: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE11
      dq_oe |-> dq_out[15:8] == `FLCS_HIGH_BYTE_STATUS)
      else $error("high byte not zero during status read");
   a_oe_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE11
      !read_active |=> !dq_oe)
      else $error("data driven outside a read");
   a_async_refresh: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE12
      async_fall |=> dq_out[7:0] == $past(operation_status))
      else $error("status not refreshed on enable fall");
   a_latch_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE12
      !refresh |=> $stable(latched))
      else $error("latched status changed without refresh");
   a_burst_refresh: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE13
      burst_tog |=> dq_out[7:0] == $past(operation_status))
      else $error("burst status not refreshed on toggle");
   a_burst_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE13
      burst_s && !burst_tog |=> $stable(latched))
      else $error("burst status changed without toggle");
   a_sticky_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE23
      operation_status[`FLCS_BIT_LOCKED] && !do_clear |=> operation_status[`FLCS_BIT_LOCKED])
      else $error("sticky lock bit dropped without clear");
   a_clear_status: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE23
      do_clear && (sticky_set == 4'h0) |=>
      (operation_status[`FLCS_BIT_ERS_ERR -: 3] == 3'h0) && !operation_status[`FLCS_BIT_LOCKED])
      else $error("clear status left a sticky bit");
   a_ready_bit: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE14
      !engine_i.ready |=>
      !operation_status[`FLCS_BIT_READY] && !operation_status[`FLCS_BIT_ERS_SUSP])
      else $error("ready bit set while busy");
   a_ready_set: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE14
      engine_i.ready |=> operation_status[`FLCS_BIT_READY])
      else $error("ready bit clear while ready");
   a_prg_susp: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE15
      !engine_i.prg_susp |=> !operation_status[`FLCS_BIT_PRG_SUSP])
      else $error("program suspend shown without suspend");
   a_ers_fail: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE16
      engine_i.ers_fail |=> operation_status[`FLCS_BIT_ERS_ERR])
      else $error("erase failure not flagged");
   a_prg_fail: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE17
      engine_i.prg_fail |=> operation_status[`FLCS_BIT_PRG_ERR])
      else $error("program failure not flagged");
   a_vpp_low: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE18
      engine_i.vpp_low |=> operation_status[`FLCS_BIT_VPP_LOW])
      else $error("supply lockout not flagged");
   a_locked_hit: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE19
      engine_i.locked_hit |=> operation_status[`FLCS_BIT_LOCKED])
      else $error("locked block hit not flagged");
   a_buffered_factory_programming_bit: assert property (@(posedge ref_clk) disable iff (!rst_b) // RULE20
      1'b1 |=> operation_status[`FLCS_BIT_BUFFERED_FACTORY_PROGRAMMING] == $past(engine_i.buffered_factory_programming_busy))
      else $error("factory program busy bit wrong");
endmodule : flcs_cmd

// ===== verification/flcs_host_model.sv
// host bus master model: command writes and status reads on the flash pins
// assumes ref_clk is the block clock; pins move on its falling edge only
`timescale 1ns/1ps
module flcs_host_model (
   input wire logic ref_clk,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic address_valid_n,
   output logic [16:0] addr,
   output logic [15:0] dq_in
);
   initial begin
      ce_n = 1'b1;
      oe_n = 1'b1;
      we_n = 1'b1;
      address_valid_n = 1'b1;
      addr = 17'h00000;
      dq_in = 16'h0000;
   end
   // released buses show the inverse so a stale sample cannot pass
   task automatic wr(input logic [16:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      ce_n = 1'b0;
      address_valid_n = 1'b0;
      addr = a;
      dq_in = d;
      @(negedge ref_clk);
      we_n = 1'b0;
      repeat (3) @(negedge ref_clk);
      we_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      ce_n = 1'b1;
      address_valid_n = 1'b1;
      addr = ~a;
      dq_in = ~d;
      repeat (5) @(negedge ref_clk);
   endtask : wr
   task automatic rd_open();
      @(negedge ref_clk);
      ce_n = 1'b0;
      oe_n = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask : rd_open
   task automatic rd_close();
      oe_n = 1'b1;
      ce_n = 1'b1;
      repeat (3) @(negedge ref_clk);
   endtask : rd_close
   // one cycle of address valid low asks a burst read for fresh status
   task automatic adv_pulse();
      @(negedge ref_clk);
      address_valid_n = 1'b0;
      @(negedge ref_clk);
      address_valid_n = 1'b1;
      repeat (3) @(negedge ref_clk);
   endtask : adv_pulse
endmodule : flcs_host_model

// ===== verification/flcs_cmd_tb.sv
// self-checking bench for the flash command interpreter
// assumes the host model drives the pins; the bench stands in for the write state machine
`timescale 1ns/1ps
module flcs_cmd_tb import flcs_pkg::*;;
   logic ref_clk, rst_b, ce_n, oe_n, we_n, address_valid_n, sync_burst;
   logic [16:0] addr;
   logic [15:0] dq_in;
   flcs_engine_t engine_i;
   logic [15:0] dq_out, read_config_register, block_locked, block_locked_down, prot_data;
   logic dq_oe, prot_prog_start, status_mode;
   logic [7:0] operation_status;
   logic [16:0] prot_addr;
   int failures, samples_checked, pulses;
   localparam logic [7:0] ENG_TAB [8] = '{8'h00, 8'h10, 8'hC0, 8'hA0, 8'h88, 8'h84, 8'h82, 8'h81};
   localparam logic [7:0] EXP_TAB [8] = '{8'h00, 8'h01, 8'hC0, 8'h84, 8'hA0, 8'hB0, 8'hB8, 8'hBA};
   flcs_host_model i_flcs_host_model (.ref_clk(ref_clk), .ce_n(ce_n), .oe_n(oe_n),
      .we_n(we_n), .address_valid_n(address_valid_n), .addr(addr), .dq_in(dq_in));
   flcs_cmd #(.NBLK(16), .BLK_LSB(12), .ADDR_SHIFT(1'b0)) i_flcs_cmd (.ref_clk(ref_clk),
      .rst_b(rst_b), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .address_valid_n(address_valid_n),
      .sync_burst(sync_burst), .addr(addr), .dq_in(dq_in), .engine_i(engine_i),
      .dq_out(dq_out), .dq_oe(dq_oe), .operation_status(operation_status),
      .read_config_register(read_config_register), .block_locked(block_locked),
      .block_locked_down(block_locked_down), .prot_prog_start(prot_prog_start),
      .prot_addr(prot_addr), .prot_data(prot_data), .status_mode(status_mode));
   initial begin
      ref_clk = 1'b0;
   end
   always #12.5 ref_clk = ~ref_clk;
   // counting pulses catches a start strobe that lasts more than one cycle
   always @(posedge ref_clk) begin
      if (prot_prog_start === 1'b1) begin
         pulses++;
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic lk(input logic [7:0] code, input logic [3:0] blk);
      i_flcs_host_model.wr({1'b0, blk, 12'h000}, 16'h0060);
      i_flcs_host_model.wr({1'b0, blk, 12'h000}, {8'h00, code});
   endtask : lk
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (5000) @(posedge ref_clk);
      failures++;
      $display("ERROR watchdog expected done seen timeout");
      conclude();
   end
   initial begin
      rst_b = 1'b0;
      sync_burst = 1'b0;
      engine_i = flcs_engine_t'(8'h80);
      failures = 0;
      samples_checked = 0;
      pulses = 0;
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_b = 1'b1;
      chk("status", 32'h80, {24'h0, operation_status});
      chk("block_locked", 32'hFFFF, {16'h0, block_locked});
      chk("block_locked_down", 32'h0, {16'h0, block_locked_down});
      $display("test reset done");
      lk(8'hD0, 4'h3);
      chk("block_locked", 32'hFFF7, {16'h0, block_locked});
      chk("status_mode", 32'h1, {31'h0, status_mode});
      i_flcs_host_model.rd_open();
      chk("dq_oe", 32'h1, {31'h0, dq_oe});
      chk("dq_out", 32'h0080, {16'h0, dq_out});
      engine_i = flcs_engine_t'(8'h00);
      repeat (4) @(negedge ref_clk);
      chk("dq_out held", 32'h0080, {16'h0, dq_out});
      i_flcs_host_model.rd_close();
      i_flcs_host_model.rd_open();
      chk("dq_out", 32'h0000, {16'h0, dq_out});
      i_flcs_host_model.rd_close();
      engine_i = flcs_engine_t'(8'h80);
      lk(8'h01, 4'h3);
      chk("block_locked", 32'hFFFF, {16'h0, block_locked});
      lk(8'h2F, 4'h5);
      chk("block_locked_down", 32'h0020, {16'h0, block_locked_down});
      lk(8'hD0, 4'h5);
      chk("block_locked", 32'hFFFF, {16'h0, block_locked});
      $display("test locking done");
      i_flcs_host_model.wr(17'h1ABCD, 16'h0060);
      i_flcs_host_model.wr(17'h1ABCD, 16'h0003);
      chk("read_config_register", 32'hABCD, {16'h0, read_config_register});
      chk("status_mode", 32'h0, {31'h0, status_mode});
      i_flcs_host_model.wr(17'h1FFFF, 16'h0070);
      chk("status_mode", 32'h1, {31'h0, status_mode});
      i_flcs_host_model.wr(17'h00000, 16'h00FF);
      chk("status_mode", 32'h0, {31'h0, status_mode});
      i_flcs_host_model.wr(17'h00000, 16'h0060);
      i_flcs_host_model.wr(17'h00000, 16'h0055);
      chk("status", 32'hB0, {24'h0, operation_status});
      chk("status_mode", 32'h1, {31'h0, status_mode});
      i_flcs_host_model.wr(17'h00000, 16'h0050);
      chk("status", 32'h80, {24'h0, operation_status});
      i_flcs_host_model.wr(17'h1ABCD, 16'h0060);
      i_flcs_host_model.wr(17'h1ABCD, 16'h00FF);
      chk("status", 32'hB0, {24'h0, operation_status});
      i_flcs_host_model.wr(17'h00000, 16'h0050);
      $display("test configuration done");
      i_flcs_host_model.wr(17'h00000, 16'h00C0);
      i_flcs_host_model.wr(17'h00080, 16'h1234);
      chk("start pulses", 32'h1, pulses);
      chk("prot_addr", 32'h00080, {15'h0, prot_addr});
      chk("prot_data", 32'h1234, {16'h0, prot_data});
      $display("test protection done");
      for (int i = 0; i < 8; i++) begin
         engine_i = flcs_engine_t'(ENG_TAB[i]);
         repeat (4) @(negedge ref_clk);
         chk("status", {24'h0, EXP_TAB[i]}, {24'h0, operation_status});
      end
      engine_i = flcs_engine_t'(8'h80);
      repeat (4) @(negedge ref_clk);
      chk("status", 32'hBA, {24'h0, operation_status});
      i_flcs_host_model.wr(17'h00000, 16'h0050);
      chk("status", 32'h80, {24'h0, operation_status});
      $display("test status flags done");
      sync_burst = 1'b1;
      i_flcs_host_model.rd_open();
      chk("dq_out burst", 32'h0080, {16'h0, dq_out});
      engine_i = flcs_engine_t'(8'h00);
      repeat (4) @(negedge ref_clk);
      chk("dq_out burst held", 32'h0080, {16'h0, dq_out});
      i_flcs_host_model.adv_pulse();
      chk("dq_out burst", 32'h0000, {16'h0, dq_out});
      i_flcs_host_model.rd_close();
      engine_i = flcs_engine_t'(8'h80);
      sync_burst = 1'b0;
      $display("test burst status done");
      conclude();
   end
endmodule : flcs_cmd_tb
